// File: hw/lcd_link_consts.svh
// Constants shared by both ends of the display serial link
`ifndef LCD_LINK_CONSTS_SVH
`define LCD_LINK_CONSTS_SVH
// ==========================================================
// Timing
`define MCLK_PERIOD_NS   40
`define LINK_QUARTER_NS  80
`define LINK_QUARTER_CYC (`LINK_QUARTER_NS / `MCLK_PERIOD_NS)
`define QCNT_W           4
// ==========================================================
// Protocol values
`define DIR_CMD_BYTE     8'he8
`define IIC_ADDR_BASE    5'h0f
`define IIC_WRITE        1'b0
`define CTRL_CO_BIT      7
`define CTRL_RS_BIT      6
`define SPI_LAST_BIT     3'h7
`define HOST_SPI_LAST    4'h7
`define IIC_ACK_BIT      4'h8
`define PS_4LINE_BIT     1
`define PS_IIC_BIT       2
`define COL_PTR_W        8
`define LINE_IDLE        1'b1
`endif

// File: hw/lcd_link_pkg.sv
// Types shared by both ends of the display serial link
`default_nettype none
`include "lcd_link_consts.svh"
package lcd_link_pkg;
   // ==========================================================
   // Enumerations
   typedef enum logic [1:0] {
      MODE_3LINE = 2'h0, MODE_4LINE = 2'h1,
      MODE_IIC   = 2'h3, MODE_NONE  = 2'h2
   } mode_t;
   typedef enum logic [1:0] {
      SEQ_CMD = 2'h0, SEQ_LEN = 2'h1, SEQ_DATA = 2'h3
   } spi_seq_t;
   typedef enum logic [1:0] {
      I_IDLE = 2'h0, I_RECV = 2'h1, I_ACK = 2'h3, I_SKIP = 2'h2
   } iic_st_t;
   typedef enum logic [1:0] {
      PH_ADDR = 2'h0, PH_CTRL = 2'h1, PH_DATA = 2'h3
   } iic_phase_t;
   typedef enum logic [2:0] {
      H_IDLE = 3'h0, H_START = 3'h1, H_BIT = 3'h3,
      H_STOP = 3'h2, H_GAP = 3'h6, H_HOLD = 3'h7
   } host_st_t;
   // ==========================================================
   // State records
   typedef struct packed {
      logic [6:0] bits;
      logic [2:0] cnt;
      logic       tog;
   } spi_link_t;
   typedef struct packed {
      logic                  cs_s1, cs_s2;
      logic [3:0]            tog_s;
      logic [2:0]            scl_s, sda_s;
      logic [2:0]            ps_s1, ps_s2;
      logic [1:0]            sa_s1, sa_s2;
      spi_seq_t              seq;
      logic [7:0]            left;
      iic_st_t               ist;
      iic_phase_t            iph;
      logic [3:0]            icnt;
      logic [7:0]            ish;
      logic                  icont, irs, sda_oe;
      logic [7:0]            out_byte;
      logic                  out_is_data, out_valid, abort;
      logic [`COL_PTR_W-1:0] col_ptr;
   } dev_state_t;
   typedef struct packed {
      host_st_t            st;
      logic [`QCNT_W-1:0]  q;
      logic [1:0]          ph, idx, last;
      logic [3:0]          bitn;
      logic [2:0][7:0]     seq;
      logic [7:0]          left;
      logic                cs_n, rs, scl, sda, sda_oe;
      logic [2:0]          ps;
      logic [1:0]          sa, sda_s;
      logic                ready, busy, nack;
   } host_state_t;
   // ==========================================================
   // Mode decode from the three select straps
   function automatic mode_t mode_of(input logic [2:0] ps);
      mode_t m;
      m = MODE_NONE;
      if (ps == 3'h0)
         m = MODE_3LINE;
      else if (ps[`PS_IIC_BIT] && !ps[`PS_4LINE_BIT] && !ps[0])
         m = MODE_IIC;
      else if (ps[`PS_4LINE_BIT] && !ps[`PS_IIC_BIT] && !ps[0])
         m = MODE_4LINE;
      return m;
   endfunction
endpackage
`default_nettype wire

// File: hw/lcd_link_if.sv
// Wires between the host controller and the display serial port
`timescale 1ns/100ps
`default_nettype none
interface lcd_link_if;
   logic chip_select_n;
   logic reg_select;
   logic serial_clock_in;
   logic serial_data_in;
   logic iface_sel_bit0, iface_sel_bit1, iface_sel_bit2;
   logic addr_pin_low, addr_pin_high;
   logic host_sda_out, host_sda_oe;
   logic dev_sda_out, dev_sda_oe;
   // Wired-and data line with pull-up
   assign serial_data_in = ~((host_sda_oe & ~host_sda_out) |
                             (dev_sda_oe & ~dev_sda_out));
   modport device (
      input  chip_select_n, reg_select, serial_clock_in,
      input  serial_data_in, iface_sel_bit0, iface_sel_bit1,
      input  iface_sel_bit2, addr_pin_low, addr_pin_high,
      output dev_sda_out, dev_sda_oe
   );
   modport host (
      output chip_select_n, reg_select, serial_clock_in,
      output iface_sel_bit0, iface_sel_bit1, iface_sel_bit2,
      output addr_pin_low, addr_pin_high, host_sda_out, host_sda_oe,
      input  serial_data_in
   );
endinterface
`default_nettype wire

// File: hw/lcd_port_device.sv
// Display serial port receiver: 3/4-line SPI and two-wire modes
`timescale 1ns/100ps
`default_nettype none
module lcd_port_device
   import lcd_link_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  reset,
   lcd_link_if.device                 link,
   output logic [7:0]                 rx_byte,
   output logic                       rx_is_data,
   output logic                       rx_valid,
   output logic [`COL_PTR_W-1:0]      column_ptr,
   output logic                       frame_abort
);
   // ==========================================================
   // Link clock domain: SPI shifter
   spi_link_t  l_r, l_nxt;
   logic [7:0] hold_byte_r, hold_byte_nxt;
   logic       hold_rs_r, hold_rs_nxt;

   // Shift in on every rising link clock edge, MSB first
   always_comb begin
      l_nxt         = l_r;
      hold_byte_nxt = hold_byte_r;
      hold_rs_nxt   = hold_rs_r;
      l_nxt.bits    = {l_r.bits[5:0], link.serial_data_in};
      l_nxt.cnt     = l_r.cnt + 3'h1;
      if (l_r.cnt == `SPI_LAST_BIT) begin
         hold_byte_nxt = {l_r.bits, link.serial_data_in};
         hold_rs_nxt   = link.reg_select;
         l_nxt.tog     = ~l_r.tog;
      end
   end

   // Deselect clears the shifter without needing a link edge
   always_ff @(posedge link.serial_clock_in or
               posedge link.chip_select_n) begin
      if (link.chip_select_n)
         l_r <= '0;
      else
         l_r <= l_nxt;
   end

   // Byte hold register, read by the main domain after the toggle
   always_ff @(posedge link.serial_clock_in) begin
      hold_byte_r <= hold_byte_nxt;
      hold_rs_r   <= hold_rs_nxt;
   end

   // ==========================================================
   // Main clock domain
   dev_state_t d_r, d_nxt;
   mode_t      mode;
   logic       spi_on, spi_evt, del, del_data;
   logic       scl_rise, scl_fall, sda_rise, sda_fall;
   logic       start_c, stop_c, ack;
   logic [7:0] del_byte;

   // Synchronisers, decode, SPI sequencing and two-wire receiver
   always_comb begin
      d_nxt           = d_r;
      del             = 1'b0;
      del_data        = 1'b0;
      del_byte        = 8'h00;
      ack             = 1'b0;
      d_nxt.out_valid = 1'b0;
      d_nxt.abort     = 1'b0;
      // Two flops on every pin before logic reads it
      d_nxt.cs_s1 = link.chip_select_n;
      d_nxt.cs_s2 = d_r.cs_s1;
      d_nxt.tog_s = {d_r.tog_s[2:0], l_r.tog};
      d_nxt.scl_s = {d_r.scl_s[1:0], link.serial_clock_in};
      d_nxt.sda_s = {d_r.sda_s[1:0], link.serial_data_in};
      d_nxt.ps_s1 = {link.iface_sel_bit2, link.iface_sel_bit1,
                     link.iface_sel_bit0};
      d_nxt.ps_s2 = d_r.ps_s1;
      d_nxt.sa_s1 = {link.addr_pin_high, link.addr_pin_low};
      d_nxt.sa_s2 = d_r.sa_s1;
      mode = mode_of(d_r.ps_s2);
      spi_on = (mode == MODE_3LINE) || (mode == MODE_4LINE);
      // Toggle compared one stage late so a deselect is seen first
      spi_evt = (d_r.tog_s[3] ^ d_r.tog_s[2]) & ~d_r.cs_s2 & spi_on;

      // SPI byte handling
      if (mode == MODE_4LINE) begin
         d_nxt.seq = SEQ_CMD;
         if (spi_evt) begin
            del      = 1'b1;
            del_byte = hold_byte_r;
            del_data = hold_rs_r;
         end
      end else if (mode == MODE_3LINE) begin
         if (d_r.cs_s2) begin
            // Deselect inside a string drops the rest of it
            if (d_r.seq != SEQ_CMD)
               d_nxt.abort = 1'b1;
            d_nxt.seq = SEQ_CMD;
         end else if (spi_evt) begin
            case (d_r.seq)
               SEQ_CMD: begin
                  if (hold_byte_r == `DIR_CMD_BYTE)
                     d_nxt.seq = SEQ_LEN;
                  else begin
                     del      = 1'b1;
                     del_byte = hold_byte_r;
                  end
               end
               SEQ_LEN: begin
                  d_nxt.left = hold_byte_r;
                  d_nxt.seq  = (hold_byte_r == 8'h00) ? SEQ_CMD
                                                       : SEQ_DATA;
               end
               SEQ_DATA: begin
                  del        = 1'b1;
                  del_data   = 1'b1;
                  del_byte   = hold_byte_r;
                  d_nxt.left = d_r.left - 8'h01;
                  if (d_r.left == 8'h01)
                     d_nxt.seq = SEQ_CMD;
               end
               default: d_nxt.seq = SEQ_CMD;
            endcase
         end
      end else begin
         d_nxt.seq = SEQ_CMD;
      end

      // Two-wire receiver, edges seen on synchronised copies
      scl_rise = d_r.scl_s[1] & ~d_r.scl_s[2];
      scl_fall = ~d_r.scl_s[1] & d_r.scl_s[2];
      sda_rise = d_r.sda_s[1] & ~d_r.sda_s[2];
      sda_fall = ~d_r.sda_s[1] & d_r.sda_s[2];
      start_c  = d_r.scl_s[1] & d_r.scl_s[2] & sda_fall;
      stop_c   = d_r.scl_s[1] & d_r.scl_s[2] & sda_rise;
      if (mode != MODE_IIC) begin
         d_nxt.ist    = I_IDLE;
         d_nxt.sda_oe = 1'b0;
      end else if (start_c) begin
         d_nxt.ist    = I_RECV;
         d_nxt.iph    = PH_ADDR;
         d_nxt.icnt   = 4'h0;
         d_nxt.sda_oe = 1'b0;
      end else if (stop_c) begin
         d_nxt.ist    = I_IDLE;
         d_nxt.sda_oe = 1'b0;
      end else begin
         case (d_r.ist)
            I_RECV: begin
               if (scl_rise && d_r.icnt != `IIC_ACK_BIT) begin
                  // One bit per clock pulse, taken while high
                  d_nxt.ish  = {d_r.ish[6:0], d_r.sda_s[1]};
                  d_nxt.icnt = d_r.icnt + 4'h1;
               end else if (scl_fall && d_r.icnt == `IIC_ACK_BIT) begin
                  case (d_r.iph)
                     PH_ADDR: begin
                        // Reads are not answered, so the line stays free
                        if (d_r.ish[7:1] == {`IIC_ADDR_BASE, d_r.sa_s2}
                            && d_r.ish[0] == `IIC_WRITE) begin
                           ack       = 1'b1;
                           d_nxt.iph = PH_CTRL;
                        end else
                           d_nxt.ist = I_SKIP;
                     end
                     PH_CTRL: begin
                        d_nxt.icont = d_r.ish[`CTRL_CO_BIT];
                        d_nxt.irs   = d_r.ish[`CTRL_RS_BIT];
                        d_nxt.iph   = PH_DATA;
                        ack         = 1'b1;
                     end
                     default: begin
                        del       = 1'b1;
                        del_byte  = d_r.ish;
                        del_data  = d_r.irs;
                        d_nxt.iph = d_r.icont ? PH_CTRL : PH_DATA;
                        ack       = 1'b1;
                     end
                  endcase
               end
            end
            I_ACK: begin
               // Release only after the ninth clock has gone low
               if (scl_fall) begin
                  d_nxt.sda_oe = 1'b0;
                  d_nxt.icnt   = 4'h0;
                  d_nxt.ist    = I_RECV;
               end
            end
            default: d_nxt.ist = d_r.ist;
         endcase
         if (ack) begin
            d_nxt.sda_oe = 1'b1;
            d_nxt.ist    = I_ACK;
         end
      end

      // Byte out, column pointer follows every data byte
      if (del) begin
         d_nxt.out_valid   = 1'b1;
         d_nxt.out_byte    = del_byte;
         d_nxt.out_is_data = del_data;
         if (del_data)
            d_nxt.col_ptr = d_r.col_ptr + `COL_PTR_W'(1);
      end
   end

   // Main domain state register
   always_ff @(posedge mclk) begin
      if (reset) begin
         d_r       <= '0;
         d_r.cs_s1 <= `LINE_IDLE;
         d_r.cs_s2 <= `LINE_IDLE;
         // Idle-high copies, so no false edge follows reset
         d_r.scl_s <= {3{`LINE_IDLE}};
         d_r.sda_s <= {3{`LINE_IDLE}};
      end else
         d_r <= d_nxt;
   end

   // ==========================================================
   // Outputs, all registered except the data line output, which is tied low
   assign rx_byte          = d_r.out_byte;
   assign rx_is_data       = d_r.out_is_data;
   assign rx_valid         = d_r.out_valid;
   assign column_ptr       = d_r.col_ptr;
   assign frame_abort      = d_r.abort;
   assign link.dev_sda_oe  = d_r.sda_oe;
   assign link.dev_sda_out = 1'b0;
endmodule
`default_nettype wire

// File: hw/lcd_port_host.sv
// Host controller end: drives SPI or two-wire frames to the display
`timescale 1ns/100ps
`default_nettype none
module lcd_port_host
   import lcd_link_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset,
   lcd_link_if.host        link,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_is_data,
   input  wire logic [7:0] tx_count,
   input  wire logic [2:0] cfg_mode_sel,
   input  wire logic [1:0] cfg_addr_sel,
   output logic            tx_ready,
   output logic            busy,
   output logic            nack_seen
);
   // ==========================================================
   // Frame engine
   host_state_t h_r, h_nxt;
   mode_t       mode;
   logic        tick, iic, last_bit;

   // Quarter-period sequencer; link clock is a divided mclk
   always_comb begin
      h_nxt       = h_r;
      h_nxt.ready = 1'b0;
      h_nxt.sda_s = {h_r.sda_s[0], link.serial_data_in};
      mode = mode_of(h_r.ps);
      iic  = (mode == MODE_IIC);
      tick = (h_r.q == `QCNT_W'(`LINK_QUARTER_CYC - 1));
      h_nxt.q  = tick ? '0 : h_r.q + `QCNT_W'(1);
      last_bit = (h_r.bitn == (iic ? `IIC_ACK_BIT : `HOST_SPI_LAST));
      case (h_r.st)
         H_IDLE: begin
            h_nxt.q  = '0;
            h_nxt.ps = cfg_mode_sel;
            h_nxt.sa = cfg_addr_sel;
            if (tx_valid && mode != MODE_NONE) begin
               h_nxt.ready = 1'b1;
               h_nxt.st    = H_START;
               h_nxt.idx   = 2'h0;
               h_nxt.bitn  = 4'h0;
               h_nxt.left  = 8'h00;
               h_nxt.last  = 2'h0;
               h_nxt.seq   = {16'h0000, tx_byte};
               if (iic) begin
                  // Start: data falls while clock is high, bus idle
                  h_nxt.sda_oe = 1'b1;
                  h_nxt.sda    = 1'b0;
                  h_nxt.seq    = {tx_byte, 1'b0, tx_is_data, 6'h00,
                                  `IIC_ADDR_BASE, h_r.sa, `IIC_WRITE};
                  h_nxt.last   = 2'h2;
               end else begin
                  h_nxt.cs_n   = 1'b0;
                  h_nxt.sda_oe = 1'b1;
                  // Select pin tied low in 3-line mode, which ignores it; two-wire leaves it as it was
                  h_nxt.rs = (mode == MODE_4LINE) & tx_is_data;
                  if (mode == MODE_3LINE && tx_is_data) begin
                     h_nxt.seq  = {tx_byte, tx_count, `DIR_CMD_BYTE};
                     h_nxt.last = 2'h2;
                     h_nxt.left = tx_count - 8'h01;
                  end
               end
            end
         end
         H_START: begin
            if (tick) begin
               h_nxt.st  = H_BIT;
               h_nxt.scl = 1'b0;
               h_nxt.ph  = 2'h0;
            end
         end
         H_BIT: begin
            if (tick) begin
               h_nxt.ph = h_r.ph + 2'h1;
               case (h_r.ph)
                  2'h0: begin
                     // Data changes only while the clock is low
                     if (iic && h_r.bitn == `IIC_ACK_BIT)
                        h_nxt.sda_oe = 1'b0;
                     else begin
                        h_nxt.sda_oe = 1'b1;
                        h_nxt.sda = h_r.seq[h_r.idx][~h_r.bitn[2:0]];
                     end
                  end
                  2'h1: h_nxt.scl = 1'b1;
                  2'h2: begin
                     if (iic && h_r.bitn == `IIC_ACK_BIT)
                        h_nxt.nack = h_r.sda_s[1];
                  end
                  default: begin
                     h_nxt.scl = 1'b0;
                     if (!last_bit)
                        h_nxt.bitn = h_r.bitn + 4'h1;
                     else begin
                        h_nxt.bitn = 4'h0;
                        h_nxt.idx  = h_r.idx + 2'h1;
                        if (h_r.idx == h_r.last) begin
                           // Keep selected while a data string runs on
                           h_nxt.st = (mode == MODE_3LINE &&
                                       h_r.left != 8'h00) ? H_HOLD
                                                          : H_STOP;
                        end
                     end
                  end
               endcase
            end
         end
         H_HOLD: begin
            h_nxt.q = '0;
            if (tx_valid) begin
               h_nxt.ready = 1'b1;
               h_nxt.seq   = {16'h0000, tx_byte};
               h_nxt.idx   = 2'h0;
               h_nxt.last  = 2'h0;
               h_nxt.left  = h_r.left - 8'h01;
               h_nxt.ph    = 2'h0;
               h_nxt.st    = H_BIT;
            end
         end
         H_STOP: begin
            if (tick) begin
               h_nxt.ph = h_r.ph + 2'h1;
               case (h_r.ph)
                  2'h0: begin
                     if (iic) begin
                        h_nxt.sda_oe = 1'b1;
                        h_nxt.sda    = 1'b0;
                     end else
                        h_nxt.cs_n = 1'b1;
                  end
                  2'h1: h_nxt.scl = 1'b1;
                  2'h2: begin
                     // Stop: data rises with clock high, line released
                     h_nxt.sda    = 1'b1;
                     h_nxt.sda_oe = 1'b0;
                  end
                  default: h_nxt.st = H_GAP;
               endcase
            end
         end
         H_GAP: begin
            if (tick)
               h_nxt.st = H_IDLE;
         end
         default: h_nxt.st = H_IDLE;
      endcase
      h_nxt.busy = (h_nxt.st != H_IDLE);
   end

   // State register
   always_ff @(posedge mclk) begin
      if (reset) begin
         h_r      <= '0;
         h_r.cs_n <= `LINE_IDLE;
         h_r.scl  <= `LINE_IDLE;
         h_r.sda  <= `LINE_IDLE;
      end else
         h_r <= h_nxt;
   end

   // ==========================================================
   // Pins and status, all registered
   assign link.chip_select_n   = h_r.cs_n;
   assign link.reg_select      = h_r.rs;
   assign link.serial_clock_in = h_r.scl;
   assign link.host_sda_out    = h_r.sda;
   assign link.host_sda_oe     = h_r.sda_oe;
   assign link.iface_sel_bit0  = h_r.ps[0];
   assign link.iface_sel_bit1  = h_r.ps[1];
   assign link.iface_sel_bit2  = h_r.ps[2];
   assign link.addr_pin_low    = h_r.sa[0];
   assign link.addr_pin_high   = h_r.sa[1];
   assign tx_ready             = h_r.ready;
   assign busy                 = h_r.busy;
   assign nack_seen            = h_r.nack;
endmodule
`default_nettype wire

// File: tb/lcd_link_checker.sv
// Wire-level checker for the display serial link
`timescale 1ns/100ps
`default_nettype none
module lcd_link_checker (
   input wire logic mclk,
   input wire logic reset,
   input wire logic chip_select_n,
   input wire logic serial_clock_in,
   input wire logic iface_sel_bit2,
   input wire logic dev_sda_oe
);
   // ==========================================================
   // Relations on the link wires, sampled on mclk
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_ack_on_low: assert property (
      $rose(dev_sda_oe) |-> !serial_clock_in)
      else $error("ack pull-down started while clock high");
   a_ack_held_high: assert property (
      $rose(serial_clock_in) && dev_sda_oe |-> dev_sda_oe [*4])
      else $error("ack dropped inside clock high phase");
   a_ack_released: assert property (
      $fell(serial_clock_in) && dev_sda_oe |-> ##[1:4] !dev_sda_oe)
      else $error("data line not released after ack");
   a_scl_high_phase: assert property (
      $rose(serial_clock_in) |-> serial_clock_in [*4])
      else $error("clock high phase too short");
   a_spi_clock_idle: assert property (
      $rose(chip_select_n) |-> ##[0:3] serial_clock_in)
      else $error("serial clock not idle after deselect");
   a_spi_clk_framed: assert property (
      $fell(serial_clock_in) && !iface_sel_bit2 |-> !chip_select_n)
      else $error("serial clock toggled while deselected");
   a_spi_dev_quiet: assert property (
      !iface_sel_bit2 |-> !dev_sda_oe)
      else $error("device drove data line in a serial mode");
   a_iic_cs_high: assert property (
      iface_sel_bit2 |-> chip_select_n)
      else $error("chip select low in two-wire mode");
   // Main scenarios reached
   c_ack: cover property ($rose(dev_sda_oe));
   c_spi_frame: cover property ($fell(chip_select_n));
   c_iic_clock: cover property ($fell(serial_clock_in) && iface_sel_bit2);
endmodule
`default_nettype wire

// File: tb/tb.sv
// Bench joining host and display ends over the serial link
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic       mclk, reset, host_kick, host_reset;
   logic       tx_valid, tx_is_data, tx_ready, busy, nack_seen;
   logic [7:0] tx_byte, tx_count, rx_byte, column_ptr;
   logic [2:0] cfg_mode_sel;
   logic [1:0] cfg_addr_sel;
   logic       rx_is_data, rx_valid, frame_abort;
   logic [8:0] rxq[$];
   int         err_total = 0, check_count = 0, cycles = 0, aborts = 0;
   lcd_link_if link_bus ();
   // Host reset can be kicked alone to cut a frame short
   assign host_reset = reset | host_kick;
   lcd_port_host u_lcd_port_host (.mclk(mclk), .reset(host_reset),
      .link(link_bus), .tx_valid(tx_valid), .tx_byte(tx_byte),
      .tx_is_data(tx_is_data), .tx_count(tx_count),
      .cfg_mode_sel(cfg_mode_sel), .cfg_addr_sel(cfg_addr_sel),
      .tx_ready(tx_ready), .busy(busy), .nack_seen(nack_seen));
   lcd_port_device u_lcd_port_device (.mclk(mclk), .reset(reset),
      .link(link_bus), .rx_byte(rx_byte), .rx_is_data(rx_is_data),
      .rx_valid(rx_valid), .column_ptr(column_ptr),
      .frame_abort(frame_abort));
   lcd_link_checker u_chk (.mclk(mclk), .reset(reset),
      .chip_select_n(link_bus.chip_select_n),
      .serial_clock_in(link_bus.serial_clock_in),
      .iface_sel_bit2(link_bus.iface_sel_bit2),
      .dev_sda_oe(link_bus.dev_sda_oe));
   // ==========================================================
   // Clock, receive monitor and hang guard
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (rx_valid === 1'b1) rxq.push_back({rx_is_data, rx_byte});
      if (frame_abort === 1'b1) aborts <= aborts + 1;
      if (cycles == 6000) begin
         err_total++;
         tally_and_finish();
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   // Straps only move while idle; device needs time to resync them
   task automatic set_mode(input logic [2:0] m);
      int n;
      for (n = 0; n < 900 && busy !== 1'b0; n++) @(posedge mclk);
      if (n == 900) err_total++;
      @(posedge mclk) #1 cfg_mode_sel = m;
      repeat (8) @(posedge mclk);
   endtask
   task automatic send(input logic [7:0] b, input logic d,
                       input logic [7:0] c);
      int n;
      @(posedge mclk) #1 tx_byte = b;
      tx_is_data = d;
      tx_count = c;
      tx_valid = 1'b1;
      for (n = 0; n < 900 && tx_ready !== 1'b1; n++) @(posedge mclk) #1;
      tx_valid = 1'b0;
      if (n == 900) err_total++;
   endtask
   task automatic expect_rx(input logic [8:0] exp);
      int n;
      for (n = 0; n < 900 && rxq.size() == 0; n++) @(posedge mclk);
      chk(rxq.size() > 0 ? rxq.pop_front() : 9'bx, exp);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // Main sequence: 4-line, 3-line string, two-wire, abort
   initial begin
      reset = 1'b1;
      host_kick = 1'b0;
      tx_valid = 1'b0;
      tx_byte = 8'h00;
      tx_is_data = 1'b0;
      tx_count = 8'h00;
      cfg_mode_sel = 3'h2;
      cfg_addr_sel = 2'h1;
      repeat (10) @(posedge mclk);
      #1 reset = 1'b0;
      repeat (8) @(posedge mclk);
      send(8'ha5, 1'b0, 8'h00);
      expect_rx(9'h0a5);
      send(8'h3c, 1'b1, 8'h00);
      expect_rx(9'h13c);
      chk({1'b0, column_ptr}, 9'h001);
      set_mode(3'h0);
      send(8'h81, 1'b0, 8'h00);
      expect_rx(9'h081);
      send(8'h11, 1'b1, 8'h02);
      send(8'h22, 1'b1, 8'h02);
      expect_rx(9'h111);
      expect_rx(9'h122);
      // Plain command right after the string; data needs a count of 1+
      send(8'h99, 1'b0, 8'h00);
      expect_rx(9'h099);
      chk({1'b0, column_ptr}, 9'h003);
      set_mode(3'h4);
      send(8'h5a, 1'b0, 8'h00);
      expect_rx(9'h05a);
      send(8'h77, 1'b1, 8'h00);
      expect_rx(9'h177);
      set_mode(3'h0);
      chk({8'h00, nack_seen}, 9'h000);
      send(8'h44, 1'b1, 8'h03);
      expect_rx(9'h144);
      @(posedge mclk) #1 host_kick = 1'b1;
      repeat (4) @(posedge mclk);
      #1 host_kick = 1'b0;
      repeat (10) @(posedge mclk);
      chk(aborts[8:0], 9'h001);
      chk(9'(rxq.size()), 9'h000);
      send(8'h66, 1'b0, 8'h00);
      expect_rx(9'h066);
      chk({1'b0, column_ptr}, 9'h005);
      tally_and_finish();
   end
endmodule
`default_nettype wire
